// ===== src/flash_pkg.sv
// shared constants for the on-chip flash bus slave
package flash_pkg;

  // ----------------------------------------------------------------
  // control/status port map
  // ----------------------------------------------------------------
  localparam logic CSR_STATUS = 1'b0;
  localparam logic CSR_CONTROL = 1'b1;
  localparam int CSR_W = 32;

  // ----------------------------------------------------------------
  // status word fields
  // ----------------------------------------------------------------
  localparam int OP_LSB = 0;
  localparam int RS_BIT = 2;
  localparam int WS_BIT = 3;
  localparam int ES_BIT = 4;
  localparam int SP_LSB = 5;
  localparam int NSECT = 5;
  localparam int PAD_LSB = 10;
  localparam logic [21:0] PAD_VAL = 22'h3fffff;

  localparam logic [1:0] OP_IDLE = 2'b00;
  localparam logic [1:0] OP_ERASE = 2'b01;
  localparam logic [1:0] OP_WRITE = 2'b10;
  localparam logic [1:0] OP_READ = 2'b11;

  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int PE_LSB = 0;
  localparam int PE_W = 20;
  localparam int SE_LSB = 20;
  localparam int SE_W = 3;
  localparam int WP_LSB = 23;
  localparam logic [31:0] CTRL_RST = 32'hffffffff;
  localparam logic [SE_W-1:0] SE_FIRST = 3'h1;
  localparam logic [SE_W-1:0] SE_LAST = 3'h5;

  // ----------------------------------------------------------------
  // data port
  // ----------------------------------------------------------------
  localparam int PAR_W = 32;
  localparam int SER_W = 1;
  localparam int WORD_W = 32;
  localparam logic [4:0] SER_LAST_BIT = 5'h1f;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS = 1000;
  localparam int PROG_CYC =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : flash_pkg

// ===== src/skid_buffer.sv
// two-entry valid/ready buffer on the read data path
`timescale 1ns/1ps
module skid_buffer #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] e0_q, e0_d, e1_q, e1_d;
  logic [1:0] cnt_q, cnt_d;

  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = e0_q;

  always_comb begin
    logic push;
    logic pop;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    e0_d = e0_q;
    e1_d = e1_q;
    cnt_d = cnt_q;
    if (pop) begin
      e0_d = e1_q;
    end
    if (push) begin
      if (cnt_q == 2'd0 || (cnt_q == 2'd1 && pop)) begin
        e0_d = in_data;
      end else begin
        e1_d = in_data;
      end
    end
    cnt_d = cnt_q + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= 2'd0;
      e0_q <= '0;
      e1_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      e0_q <= e0_d;
      e1_q <= e1_d;
    end
  end

endmodule : skid_buffer

// ===== src/flash_store.sv
// word array of the user flash, one address shared by the read and the write port
`timescale 1ns/1ps
module flash_store #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_data
);

  logic [31:0] mem [2**ADDR_W];

  assign rd_data = mem[addr];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
  end

endmodule : flash_store

// ===== src/onchip_flash_bus_slave.sv
// bus-slave front end of the on-chip user flash
// Functional notes
// - one clock; active-low reset clears status, sets control to all ones, released on a clock edge
// - control registers are decoded from a one-bit control address
// - control port has 32-bit read and write data, separate strobes
// - data port words are 32 bits parallel, one bit serial
// - data port address width is a build parameter
// - wait request stays high while a read, erase or write program is in progress, low while serial write bits are collected
// - read data valid marks every cycle with a valid read word
// - incrementing read bursts: 1..2^width-1 beats in both modes, count 0 reads one; a serial beat is one bit
// - wrapping bursts only in parallel mode, length 2 or 4
// - control address 0 is read-only status, 1 is control
// - status bits 1:0 give idle, erasing, writing or reading
`timescale 1ns/1ps
module onchip_flash_bus_slave #(
  parameter bit SERIAL = 1'b0,
  parameter int ADDR_W = 12,
  parameter int BURST_W = 2,
  parameter bit WRAP = 1'b0,
  parameter int WRAP_LEN = 2,
  parameter int PAGE_SHIFT = 4,
  parameter int SECT_SHIFT = 10,
  parameter logic [4:0] SP_INIT = 5'h00,
  parameter int DW = SERIAL ? flash_pkg::SER_W : flash_pkg::PAR_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic csr_addr,
  input wire logic csr_read,
  output logic [flash_pkg::CSR_W-1:0] csr_readdata,
  input wire logic csr_write,
  input wire logic [flash_pkg::CSR_W-1:0] csr_writedata,
  input wire logic [ADDR_W-1:0] data_addr,
  input wire logic data_read,
  output logic [DW-1:0] data_readdata,
  input wire logic data_write,
  input wire logic [DW-1:0] data_writedata,
  input wire logic [BURST_W-1:0] data_burstcount,
  output logic data_waitrequest,
  output logic data_readdatavalid,
  input wire logic data_rd_ready
);
  import flash_pkg::*;

  // ----------------------------------------------------------------
  // types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_READ, S_COLLECT, S_PROG, S_ERASE
  } state_e;

  localparam logic [ADDR_W-1:0] PAGE_MASK =
    ADDR_W'((1 << PAGE_SHIFT) - 1);
  localparam logic [ADDR_W-1:0] WRAP_MASK = ADDR_W'(WRAP_LEN - 1);

  // sector id of a word address
  function automatic logic [SE_W-1:0] sector_of(
    input logic [ADDR_W-1:0] a
  );
    logic [ADDR_W-1:0] s;
    s = a >> SECT_SHIFT;
    return SE_W'(s) + SE_FIRST;
  endfunction : sector_of

  // a sector is locked by the fixed setting or by software protection
  function automatic logic locked(
    input logic [SE_W-1:0] id,
    input logic [NSECT-1:0] wp
  );
    logic [NSECT-1:0] lk;
    lk = SP_INIT | wp;
    if (id < SE_FIRST || id > SE_LAST) begin
      return 1'b1;
    end
    return lk[id - SE_FIRST];
  endfunction : locked

  // next word of a read burst, wrapping on the burst boundary only in parallel mode with WRAP set
  function automatic logic [ADDR_W-1:0] next_addr(
    input logic [ADDR_W-1:0] a
  );
    logic [ADDR_W-1:0] n;
    n = a + ADDR_W'(1);
    if (WRAP && !SERIAL) begin
      n = (a & ~WRAP_MASK) | (n & WRAP_MASK);
    end
    return n;
  endfunction : next_addr

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_e state_q, state_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [BURST_W-1:0] left_q, left_d;
  logic [ADDR_W:0] cnt_q, cnt_d;
  logic [4:0] bit_q, bit_d;
  logic [WORD_W-1:0] wbuf_q, wbuf_d;
  logic ok_q, ok_d;
  logic rs_q, rs_d, ws_q, ws_d, es_q, es_d;
  logic [CSR_W-1:0] ctrl_q, ctrl_d;
  logic [CSR_W-1:0] csr_rd_q, csr_rd_d;

  logic [WORD_W-1:0] word;
  logic mem_we;
  logic [WORD_W-1:0] mem_wd;
  logic push;
  logic push_ready;
  logic [DW-1:0] push_data;
  logic pop_valid;
  logic [1:0] op;
  logic [NSECT-1:0] wp;
  logic [CSR_W-1:0] status;

  assign wp = ctrl_q[WP_LSB +: NSECT];

  // ----------------------------------------------------------------
  // storage and read buffer
  // ----------------------------------------------------------------
  flash_store #(
    .ADDR_W(ADDR_W)
  ) u_flash_store (
    .clk(clk),
    .wr_en(mem_we),
    .addr(addr_q),
    .wr_data(mem_wd),
    .rd_data(word)
  );

  skid_buffer #(
    .W(DW)
  ) u_skid_buffer (
    .clk(clk),
    .nrst(nrst),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(data_rd_ready),
    .out_data(data_readdata)
  );

  assign data_readdatavalid = pop_valid && data_rd_ready;

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  always_comb begin
    op = OP_IDLE;
    unique case (state_q)
      S_IDLE: op = OP_IDLE;
      S_ERASE: op = OP_ERASE;
      S_COLLECT, S_PROG: op = OP_WRITE;
      S_READ: op = OP_READ;
    endcase
    status = '0;
    status[OP_LSB +: 2] = op;
    status[RS_BIT] = rs_q;
    status[WS_BIT] = ws_q;
    status[ES_BIT] = es_q;
    status[SP_LSB +: NSECT] = SP_INIT;
    status[PAD_LSB +: 22] = PAD_VAL;
  end

  // ----------------------------------------------------------------
  // wait request
  // ----------------------------------------------------------------
  // only serial write collection takes beats while not idle
  assign data_waitrequest =
    !(state_q == S_IDLE || state_q == S_COLLECT);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic [SE_W-1:0] se;
    logic [PE_W-1:0] pe;
    se = csr_writedata[SE_LSB +: SE_W];
    pe = csr_writedata[PE_LSB +: PE_W];
    state_d = state_q;
    addr_d = addr_q;
    left_d = left_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    wbuf_d = wbuf_q;
    ok_d = ok_q;
    rs_d = rs_q;
    ws_d = ws_q;
    es_d = es_q;
    ctrl_d = ctrl_q;
    csr_rd_d = csr_rd_q;
    mem_we = 1'b0;
    mem_wd = '1;
    push = 1'b0;
    push_data = '0;

    if (csr_read) begin
      csr_rd_d = (csr_addr == CSR_STATUS) ? status : ctrl_q;
    end

    unique case (state_q)
      S_IDLE: begin
        if (csr_write && csr_addr == CSR_CONTROL) begin
          ctrl_d = csr_writedata;
          if (pe != {PE_W{1'b1}}) begin
            addr_d = ADDR_W'(pe) & ~PAGE_MASK;
            cnt_d = (ADDR_W + 1)'(1 << PAGE_SHIFT);
            ok_d = !locked(sector_of(ADDR_W'(pe)),
                           csr_writedata[WP_LSB +: NSECT]);
            state_d = S_ERASE;
          end else if (se >= SE_FIRST && se <= SE_LAST) begin
            addr_d = ADDR_W'(se - SE_FIRST) << SECT_SHIFT;
            cnt_d = (ADDR_W + 1)'(1 << SECT_SHIFT);
            ok_d = !locked(se, csr_writedata[WP_LSB +: NSECT]);
            state_d = S_ERASE;
          end
        end else if (data_read) begin
          addr_d = data_addr;
          left_d = (data_burstcount == '0) ? BURST_W'(1)
                                           : data_burstcount;
          ok_d = !locked(sector_of(data_addr), wp);
          bit_d = '0;
          state_d = S_READ;
        end else if (data_write) begin
          addr_d = data_addr;
          if (SERIAL) begin
            wbuf_d = '1;
            wbuf_d[0] = data_writedata[0];
            bit_d = 5'h1;
            state_d = S_COLLECT;
          end else begin
            wbuf_d = WORD_W'(data_writedata);
            cnt_d = (ADDR_W + 1)'(PROG_CYC);
            state_d = S_PROG;
          end
        end
      end
      S_COLLECT: begin
        if (data_write) begin
          wbuf_d[bit_q] = data_writedata[0];
          bit_d = bit_q + 5'h1;
          if (bit_q == SER_LAST_BIT) begin
            cnt_d = (ADDR_W + 1)'(PROG_CYC);
            state_d = S_PROG;
          end
        end
      end
      S_PROG: begin
        cnt_d = cnt_q - (ADDR_W + 1)'(1);
        if (cnt_q == (ADDR_W + 1)'(1)) begin
          // programming only clears bits
          mem_we = !locked(sector_of(addr_q), wp);
          mem_wd = word & wbuf_q;
          ws_d = mem_we;
          state_d = S_IDLE;
        end
      end
      S_ERASE: begin
        mem_we = ok_q;
        mem_wd = '1;
        addr_d = addr_q + ADDR_W'(1);
        cnt_d = cnt_q - (ADDR_W + 1)'(1);
        if (cnt_q == (ADDR_W + 1)'(1)) begin
          es_d = ok_q;
          state_d = S_IDLE;
        end
      end
      S_READ: begin
        push = 1'b1;
        if (SERIAL) begin
          push_data = DW'(ok_q ? word[bit_q] : 1'b1);
        end else begin
          push_data = DW'(ok_q ? word : '1);
        end
        if (push_ready) begin
          if (!SERIAL || bit_q == SER_LAST_BIT) begin
            addr_d = next_addr(addr_q);
          end
          bit_d = bit_q + 5'h1;
          left_d = left_q - BURST_W'(1);
          if (left_q == BURST_W'(1)) begin
            rs_d = ok_q;
            state_d = S_IDLE;
          end
        end
      end
    endcase

    // protection bits may be changed while an operation runs
    if (state_q != S_IDLE && csr_write && csr_addr == CSR_CONTROL) begin
      ctrl_d[WP_LSB +: NSECT] = csr_writedata[WP_LSB +: NSECT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      addr_q <= '0;
      left_q <= '0;
      cnt_q <= '0;
      bit_q <= '0;
      wbuf_q <= '1;
      ok_q <= 1'b0;
      rs_q <= 1'b0;
      ws_q <= 1'b0;
      es_q <= 1'b0;
      ctrl_q <= CTRL_RST;
      csr_rd_q <= '0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      left_q <= left_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      wbuf_q <= wbuf_d;
      ok_q <= ok_d;
      rs_q <= rs_d;
      ws_q <= ws_d;
      es_q <= es_d;
      ctrl_q <= ctrl_d;
      csr_rd_q <= csr_rd_d;
    end
  end

  assign csr_readdata = csr_rd_q;

endmodule : onchip_flash_bus_slave

// ===== testbench/flash_bus_slave_sva.sv
// port assertions for the flash bus slave
`timescale 1ns/1ps
module flash_bus_slave_sva #(
  parameter int BURST_W = 2,
  parameter logic [4:0] SP_INIT = 5'h00
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic csr_addr,
  input wire logic csr_read,
  input wire logic [31:0] csr_readdata,
  input wire logic data_read,
  input wire logic data_write,
  input wire logic [BURST_W-1:0] data_burstcount,
  input wire logic data_waitrequest,
  input wire logic data_readdatavalid,
  input wire logic data_rd_ready
);
  logic rd_go;
  logic wr_go;
  assign rd_go = data_read && !data_waitrequest;
  assign wr_go = data_write && !data_read && !data_waitrequest;
  // read beats requested but not yet delivered
  logic [15:0] beats;
  logic [15:0] pend_q, pend_d;
  assign beats = !rd_go ? 16'h0 :
    (data_burstcount == '0) ? 16'h1 : 16'(data_burstcount);
  assign pend_d = pend_q + beats - 16'(data_readdatavalid);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_q <= 16'h0;
    end else begin
      pend_q <= pend_d;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_rst;
    disable iff (1'b0) !nrst |=> csr_readdata == 32'h0
      && !data_waitrequest && !data_readdatavalid;
  endproperty
  property p_stat;
    csr_read && !csr_addr |=> csr_readdata[31:5] == {22'h3fffff, SP_INIT};
  endproperty
  property p_hold;
    !csr_read |=> $stable(csr_readdata);
  endproperty
  property p_wr;
    wr_go |=> data_waitrequest[*8] ##17 data_waitrequest
      ##1 !data_waitrequest;
  endproperty
  property p_rdw;
    rd_go |=> data_waitrequest;
  endproperty
  property p_vr;
    data_readdatavalid |-> data_rd_ready && pend_q != 16'h0;
  endproperty
  property p_rd2;
    rd_go && data_rd_ready && data_burstcount == 2
      |-> ##2 data_readdatavalid ##1 data_readdatavalid;
  endproperty
  property p_first;
    rd_go && data_rd_ready |=> !data_readdatavalid;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_stat: assert property (p_stat) else $error("status bits wrong");
  a_hold: assert property (p_hold) else $error("readdata moved");
  a_wr: assert property (p_wr) else $error("write busy time wrong");
  a_rdw: assert property (p_rdw) else $error("read not busy");
  a_vr: assert property (p_vr) else $error("valid while stalled");
  a_rd2: assert property (p_rd2) else $error("burst beats wrong");
  a_first: assert property (p_first) else $error("valid too early");
  c_wr: cover property (wr_go);
  c_rd: cover property (rd_go && data_burstcount == 2);
  c_st: cover property (csr_read && !csr_addr);
endmodule : flash_bus_slave_sva

bind onchip_flash_bus_slave flash_bus_slave_sva #(
  .BURST_W(BURST_W),
  .SP_INIT(SP_INIT)
) u_flash_bus_slave_sva (
  .clk(clk), .nrst(nrst), .csr_addr(csr_addr), .csr_read(csr_read),
  .csr_readdata(csr_readdata), .data_read(data_read),
  .data_write(data_write), .data_burstcount(data_burstcount),
  .data_waitrequest(data_waitrequest),
  .data_readdatavalid(data_readdatavalid), .data_rd_ready(data_rd_ready)
);

// ===== testbench/flash_master.sv
// bus master model for the flash data port
`timescale 1ns/1ps
module flash_master #(
  parameter int AW = 12,
  parameter int BW = 2
) (
  input wire logic clk,
  input wire logic data_waitrequest,
  output logic [AW-1:0] data_addr,
  output logic data_read,
  output logic data_write,
  output logic [31:0] data_writedata,
  output logic [BW-1:0] data_burstcount
);
  initial begin
    data_addr = '0;
    data_read = 1'b0;
    data_write = 1'b0;
    data_writedata = '0;
    data_burstcount = '0;
  end
  // ----------------------------------------------------------------
  // one transfer, held until the slave takes it
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [AW-1:0] a,
                      input logic [31:0] d, input logic [BW-1:0] n);
    @(posedge clk);
    #1;
    data_read = !wr;
    data_write = wr;
    data_addr = a;
    data_writedata = d;
    data_burstcount = wr ? BW'(1) : n;
    @(posedge clk);
    // a hang here is caught by the bench watchdog
    while (data_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    #1;
    data_read = 1'b0;
    data_write = 1'b0;
    data_addr = ~a;
    data_writedata = ~d;
    data_burstcount = ~n;
  endtask : xfer
endmodule : flash_master

// ===== testbench/onchip_flash_bus_slave_bench.sv
// self-checking bench for the flash bus slave
`timescale 1ns/1ps
module onchip_flash_bus_slave_bench;
  import flash_pkg::*;
  localparam logic [31:0] ST0 = 32'hfffffc40;
  logic clk, nrst, csr_addr, csr_read, csr_write, data_rd_ready;
  logic [31:0] csr_readdata, csr_writedata, data_readdata, data_writedata;
  logic [11:0] data_addr;
  logic [1:0] data_burstcount;
  logic data_read, data_write, data_waitrequest, data_readdatavalid;
  logic [31:0] exp_d[$];
  logic [31:0] exp_c[$];
  logic [31:0] seed = 32'h3;
  logic [31:0] w0;
  logic rd_seen = 1'b0;
  int n_fail = 0;
  int checks_done = 0;

  onchip_flash_bus_slave #(.SP_INIT(5'h02)) u_onchip_flash_bus_slave (
    .clk(clk), .nrst(nrst), .csr_addr(csr_addr), .csr_read(csr_read),
    .csr_readdata(csr_readdata), .csr_write(csr_write),
    .csr_writedata(csr_writedata), .data_addr(data_addr),
    .data_read(data_read), .data_readdata(data_readdata),
    .data_write(data_write), .data_writedata(data_writedata),
    .data_burstcount(data_burstcount), .data_waitrequest(data_waitrequest),
    .data_readdatavalid(data_readdatavalid), .data_rd_ready(data_rd_ready)
  );
  flash_master u_flash_master (
    .clk(clk), .data_waitrequest(data_waitrequest), .data_addr(data_addr),
    .data_read(data_read), .data_write(data_write),
    .data_writedata(data_writedata), .data_burstcount(data_burstcount)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic csr_rd(input logic a, input logic [31:0] e);
    exp_c.push_back(e);
    @(posedge clk);
    #1;
    csr_addr = a;
    csr_read = 1'b1;
    @(posedge clk);
    #1;
    csr_read = 1'b0;
  endtask : csr_rd
  task automatic csr_wr(input logic a, input logic [31:0] d);
    @(posedge clk);
    #1;
    csr_addr = a;
    csr_write = 1'b1;
    csr_writedata = d;
    @(posedge clk);
    #1;
    csr_write = 1'b0;
    csr_writedata = ~d;
  endtask : csr_wr
  task automatic settle();
    int k;
    k = 0;
    while (exp_d.size() != 0 || data_waitrequest !== 1'b0) begin
      @(posedge clk);
      k++;
      if (k == 2000) begin
        n_fail++;
        $display("[ERR] t=%0t settle got=%h exp=%h", $time, k, 0);
        return;
      end
    end
  endtask : settle
  task automatic summarize();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // output watcher
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (data_readdatavalid === 1'b1) begin
      chk(data_readdata, exp_d.pop_front());
    end
    if (rd_seen) begin
      chk(csr_readdata, exp_c.pop_front());
    end
    rd_seen = (csr_read === 1'b1) && (nrst === 1'b1);
  end
  initial begin
    #(40 * 4000);
    n_fail++;
    summarize();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    csr_addr = 1'b0;
    csr_read = 1'b0;
    csr_write = 1'b0;
    csr_writedata = '0;
    data_rd_ready = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    csr_rd(CSR_STATUS, ST0);
    csr_rd(CSR_CONTROL, CTRL_RST);
    csr_wr(CSR_STATUS, 32'h0);
    csr_rd(CSR_STATUS, ST0);
    csr_wr(CSR_CONTROL, 32'hff700010);
    csr_rd(CSR_STATUS, ST0 | 32'h01);
    settle();
    csr_rd(CSR_STATUS, ST0 | 32'h10);
    w0 = xs();
    u_flash_master.xfer(1'b1, 12'h010, w0, 2'h1);
    csr_rd(CSR_STATUS, ST0 | 32'h12);
    settle();
    exp_d.push_back(w0);
    exp_d.push_back(32'hffffffff);
    u_flash_master.xfer(1'b0, 12'h010, xs(), 2'h2);
    settle();
    csr_rd(CSR_STATUS, ST0 | 32'h1c);
    data_rd_ready = 1'b0;
    exp_d.push_back(w0);
    exp_d.push_back(32'hffffffff);
    u_flash_master.xfer(1'b0, 12'h010, xs(), 2'h2);
    csr_rd(CSR_STATUS, ST0 | 32'h1f);
    repeat (4) @(posedge clk);
    #1;
    data_rd_ready = 1'b1;
    settle();
    exp_d.push_back(32'hffffffff);
    u_flash_master.xfer(1'b0, 12'h400, xs(), 2'h1);
    settle();
    csr_rd(CSR_STATUS, ST0 | 32'h18);
    // sector erase of sector 1, then the erased word reads back as ones
    csr_wr(CSR_CONTROL, 32'hff1fffff);
    csr_rd(CSR_STATUS, ST0 | 32'h19);
    settle();
    exp_d.push_back(32'hffffffff);
    u_flash_master.xfer(1'b0, 12'h010, xs(), 2'h1);
    settle();
    csr_rd(CSR_STATUS, ST0 | 32'h1c);
    csr_rd(CSR_CONTROL, 32'hff1fffff);
    // second reset in mid-run
    @(posedge clk);
    #1;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    csr_rd(CSR_CONTROL, CTRL_RST);
    csr_rd(CSR_STATUS, ST0);
    repeat (2) @(posedge clk);
    summarize();
  end
endmodule : onchip_flash_bus_slave_bench
